// [hw/dtc_timer.sv]
// dual 8-bit timer/counter, cascadable to 16 bits, with ahb-lite registers
// Operation
// RULE1 - start from zero, match sets flag, restarts
// RULE2 - match flag sets regardless of enable
// RULE3 - irq while flag and enable both set
// RULE4 - writing zero to flag clears it
// RULE5 - two timers share one irq line
// RULE6 - no flag when match meets stop write
// RULE7 - enabling with flag set raises irq immediately
// RULE8 - match inverts wave; pin driven when enabled
// RULE9 - cascade compares b:a against sixteen bit count
// RULE10 - cascade clears all sixteen bits together
// RULE11 - cascade governed by timer a control
// RULE12 - cascade uses timer a flag, enable, wave
// RULE13 - counter function counts external input edges
// RULE14 - software reads running cascade count twice
// RULE15 - initial level loads only while stopped
// RULE16 - level latched by 01/10, pin kept
// RULE17 - writing 11 while stopped drives latched level
// RULE18 - start rising edge clears and starts counting
// RULE19 - pause holds count; resume keeps value
// RULE20 - pause/start code meanings and start effects
// RULE21 - stop mode freezes count, resumes later
// RULE22 - watch mode acts like stop mode
// RULE23 - software reinitialises timer after wake-up
// RULE24 - compare latch loads at start or match
// RULE25 - timer b clock select 11 cascades
// RULE26 - data register read returns counter
// RULE27 - carry from a into b when cascaded
`timescale 1ns/1ns
module dtc_timer (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // external count inputs
  input  wire logic        timer_a_ext_count,
  input  wire logic        timer_b_ext_count,
  // standby modes
  input  wire logic        stop_mode,
  input  wire logic        watch_mode,
  // outputs
  output logic             timer_a_wave_pin,
  output logic             timer_b_wave_pin,
  output logic             shared_timer_irq
);
  typedef struct packed {
    logic [7:0] data_a;
    logic [7:0] data_b;
    logic [7:0] latch_a;
    logic [7:0] latch_b;
    logic [7:0] cnt_a;
    logic [7:0] cnt_b;
    logic [1:0] clksel_a;
    logic [1:0] clksel_b;
    logic [1:0] start;
    logic [1:0] pause;
    logic [1:0] irq_en;
    logic [1:0] flag;
    logic [1:0] ext_q;
    logic [1:0] div;
  } dtc_state_type;

  dtc_state_type q;
  dtc_state_type c;

  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_addr;
  logic [31:0] rd_word;
  logic        wr_ctl_a;
  logic        wr_ctl_b;
  logic        wr_data_a;
  logic        wr_data_b;
  logic        tick_int;
  logic [1:0]  ext_edge;
  logic        cascade;
  logic        standby;
  logic        tk_a;
  logic        tk_b;
  logic        run_a;
  logic        run_b;
  logic        match_a;
  logic        match_b;
  logic        ev_a;
  logic        ev_b;
  logic        stop_a;
  logic        stop_b;
  logic        set_a;
  logic        set_b;
  logic        rise_a;
  logic        rise_b;
  logic [1:0]  wf_a;
  logic [1:0]  wf_b;

  dtc_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (rd_addr),
    .rd_word   (rd_word)
  );

  // register decode
  assign wr_ctl_a  = wr_en && (wr_addr == dtc_pkg::OFS_CTRL_A);
  assign wr_ctl_b  = wr_en && (wr_addr == dtc_pkg::OFS_CTRL_B);
  assign wr_data_a = wr_en && (wr_addr == dtc_pkg::OFS_DATA_A);
  assign wr_data_b = wr_en && (wr_addr == dtc_pkg::OFS_DATA_B);

  // count clock sources
  assign tick_int = (q.div == dtc_pkg::TICK_LAST);
  assign ext_edge = {timer_b_ext_count, timer_a_ext_count} & ~q.ext_q;
  assign cascade  = (q.clksel_b == dtc_pkg::CLK_CASCADE); // RULE25
  assign standby  = stop_mode || watch_mode;
  assign tk_a     = (q.clksel_a == dtc_pkg::CLK_EXT) ? ext_edge[0] : tick_int; // RULE13
  assign tk_b     = (q.clksel_b == dtc_pkg::CLK_EXT) ? ext_edge[1] : tick_int; // RULE13

  // running: started, not paused, not in stop or watch mode
  assign run_a = q.start[0] && !q.pause[0] && !standby; // RULE20 RULE21 RULE22
  assign run_b = q.start[1] && !q.pause[1] && !standby && !cascade; // RULE11

  // compare against the latch, 16 bits wide when cascaded
  assign match_a = cascade ? ({q.cnt_b, q.cnt_a} == {q.latch_b, q.latch_a}) : (q.cnt_a == q.latch_a); // RULE9
  assign match_b = (q.cnt_b == q.latch_b);
  assign ev_a    = run_a && tk_a && match_a;
  assign ev_b    = run_b && tk_b && match_b; // RULE5

  // a stop written in the match cycle suppresses the flag
  assign stop_a = wr_ctl_a && !wr_data[dtc_pkg::BIT_START];
  assign stop_b = wr_ctl_b && !wr_data[dtc_pkg::BIT_START];
  assign set_a  = ev_a && !stop_a; // RULE6
  assign set_b  = ev_b && !stop_b; // RULE6
  assign rise_a = wr_ctl_a && wr_data[dtc_pkg::BIT_START] && !q.start[0];
  assign rise_b = wr_ctl_b && wr_data[dtc_pkg::BIT_START] && !q.start[1] && !cascade;

  // one shared request line, level while any enabled flag is set
  assign shared_timer_irq = |(q.flag & q.irq_en); // RULE3 RULE5 RULE7 RULE12

  always_comb begin
    c       = q;
    c.ext_q = {timer_b_ext_count, timer_a_ext_count};
    c.div   = tick_int ? dtc_pkg::TICK_ZERO : q.div + 2'h1;
    // timer a, or the whole cascade
    if (ev_a) begin
      c.cnt_a   = dtc_pkg::CNT_ZERO; // RULE1
      c.latch_a = q.data_a; // RULE24
      if (cascade) begin
        c.cnt_b   = dtc_pkg::CNT_ZERO; // RULE10
        c.latch_b = q.data_b; // RULE24
      end
    end else if (run_a && tk_a) begin
      c.cnt_a = q.cnt_a + 8'h01; // RULE1
      if (cascade && (q.cnt_a == dtc_pkg::CNT_TOP)) begin
        c.cnt_b = q.cnt_b + 8'h01; // RULE27
      end
    end
    // timer b alone
    if (ev_b) begin
      c.cnt_b   = dtc_pkg::CNT_ZERO; // RULE1
      c.latch_b = q.data_b; // RULE24
    end else if (run_b && tk_b) begin
      c.cnt_b = q.cnt_b + 8'h01; // RULE1
    end
    // control a
    if (wr_ctl_a) begin
      c.start[0] = wr_data[dtc_pkg::BIT_START];
      c.pause[0] = wr_data[dtc_pkg::BIT_PAUSE]; // RULE19
      c.clksel_a = wr_data[dtc_pkg::BIT_CLK_HI:dtc_pkg::BIT_CLK_LO];
      c.irq_en[0] = wr_data[dtc_pkg::BIT_IRQ_EN];
      if (!wr_data[dtc_pkg::BIT_FLAG]) begin
        c.flag[0] = 1'b0; // RULE4
      end
    end
    if (rise_a) begin
      c.cnt_a   = dtc_pkg::CNT_ZERO; // RULE18 RULE20
      c.latch_a = q.data_a; // RULE24
      if (cascade) begin
        c.cnt_b   = dtc_pkg::CNT_ZERO; // RULE10 RULE11
        c.latch_b = q.data_b; // RULE24
      end
    end
    // control b
    if (wr_ctl_b) begin
      c.start[1] = wr_data[dtc_pkg::BIT_START];
      c.pause[1] = wr_data[dtc_pkg::BIT_PAUSE]; // RULE19
      c.clksel_b = wr_data[dtc_pkg::BIT_CLK_HI:dtc_pkg::BIT_CLK_LO]; // RULE25
      c.irq_en[1] = wr_data[dtc_pkg::BIT_IRQ_EN];
      if (!wr_data[dtc_pkg::BIT_FLAG]) begin
        c.flag[1] = 1'b0; // RULE4
      end
    end
    if (rise_b) begin
      c.cnt_b   = dtc_pkg::CNT_ZERO; // RULE18 RULE20
      c.latch_b = q.data_b; // RULE24
    end
    // hardware set wins over a software clear
    if (set_a) begin
      c.flag[0] = 1'b1; // RULE1 RULE2 RULE12
    end
    if (set_b) begin
      c.flag[1] = 1'b1; // RULE2
    end
    // compare data, taken into the latch later
    if (wr_data_a) begin
      c.data_a = wr_data; // RULE24
    end
    if (wr_data_b) begin
      c.data_b = wr_data; // RULE24
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= c;
    end
  end

  // read mux; data offsets return the live count
  always_comb begin
    rd_word = dtc_pkg::RD_ZERO;
    case (rd_addr)
      dtc_pkg::OFS_CTRL_A: begin
        rd_word[7:0] = {q.flag[0], q.irq_en[0], wf_a, q.clksel_a, q.pause[0], q.start[0]};
      end
      dtc_pkg::OFS_CTRL_B: begin
        rd_word[7:0] = {q.flag[1], q.irq_en[1], wf_b, q.clksel_b, q.pause[1], q.start[1]};
      end
      dtc_pkg::OFS_DATA_A: begin
        rd_word[7:0] = q.cnt_a; // RULE26
      end
      dtc_pkg::OFS_DATA_B: begin
        rd_word[7:0] = q.cnt_b; // RULE26
      end
      default: begin
        rd_word = dtc_pkg::RD_ZERO;
      end
    endcase
  end

  // square-wave outputs; in cascade only timer a toggles
  dtc_wave u_wave_a (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ctl_wr  (wr_ctl_a),
    .ctl_val (wr_data[dtc_pkg::BIT_WAVE_HI:dtc_pkg::BIT_WAVE_LO]),
    .stopped (!q.start[0]),
    .toggle  (ev_a),
    .field   (wf_a),
    .pin     (timer_a_wave_pin)
  );

  dtc_wave u_wave_b (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ctl_wr  (wr_ctl_b),
    .ctl_val (wr_data[dtc_pkg::BIT_WAVE_HI:dtc_pkg::BIT_WAVE_LO]),
    .stopped (!q.start[1]),
    .toggle  (ev_b),
    .field   (wf_b),
    .pin     (timer_b_wave_pin)
  );

  default clocking dtc_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_flag_on_match: assert property (set_a |=> q.flag[0]) // RULE1
    else $error("timer a flag not set on match");

  a_flag_no_enable: assert property (set_a && !q.irq_en[0] |=> q.flag[0]) // RULE2
    else $error("timer a flag depends on enable");

  a_irq_from_flag: assert property (q.flag[1] && q.irq_en[1] |-> shared_timer_irq) // RULE3
    else $error("irq missing for enabled timer b flag");

  a_flag_clear: assert property (wr_ctl_a && !wr_data[dtc_pkg::BIT_FLAG] && !set_a |=> !q.flag[0]) // RULE4
    else $error("flag not cleared by zero write");

  a_stop_no_flag: assert property (ev_a && stop_a && !q.flag[0] |=> !q.flag[0]) // RULE6
    else $error("flag set although stop written with match");

  a_enable_raises: assert property ($rose(q.irq_en[0]) && q.flag[0] |-> shared_timer_irq) // RULE7
    else $error("enabling with flag set did not raise irq");

  a_wave_toggle: assert property (ev_a && (wf_a != dtc_pkg::WAVE_OFF) && !wr_ctl_a
                                  |=> timer_a_wave_pin != $past(timer_a_wave_pin)) // RULE8
    else $error("wave pin did not invert on match");

  a_cascade_clear: assert property (cascade && ev_a |=> (q.cnt_a == dtc_pkg::CNT_ZERO) && (q.cnt_b == dtc_pkg::CNT_ZERO)) // RULE10
    else $error("cascade not cleared as a whole");

  a_cascade_carry: assert property (cascade && run_a && tk_a && !match_a && (q.cnt_a == dtc_pkg::CNT_TOP) && !wr_en
                                    |=> q.cnt_b == $past(q.cnt_b) + 8'h01) // RULE27
    else $error("carry not passed into upper byte");

  a_start_clears: assert property (rise_a && !cascade |=> q.cnt_a == dtc_pkg::CNT_ZERO && q.latch_a == $past(q.data_a)) // RULE18
    else $error("start edge did not clear and load");

  a_standby_hold: assert property (standby && !wr_en |=> $stable(q.cnt_a) && $stable(q.cnt_b)) // RULE21
    else $error("count moved in stop or watch mode");

  a_pause_hold: assert property (q.start[0] && q.pause[0] && !wr_en ##1 !wr_en |-> $stable(q.cnt_a)) // RULE19
    else $error("suspended count moved");

  a_tick_rate: assert property ((q.clksel_a != dtc_pkg::CLK_EXT) && run_a && tk_a && !wr_en
                                |=> !tk_a [*3]) // RULE1
    else $error("internal tick faster than its period");

  c_match_8bit: cover property (ev_a && !cascade ##1 q.flag[0]);
  c_match_16bit: cover property (cascade && ev_a);
  c_match_b: cover property (ev_b && q.irq_en[1] ##1 shared_timer_irq);
  c_ext_count: cover property ((q.clksel_a == dtc_pkg::CLK_EXT) && run_a && ext_edge[0]);
endmodule

// [inc/dtc_pkg.sv]
// constants shared by the dual cascadable timer design
package dtc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_DATA_A = 8'h08;
  localparam logic [7:0] OFS_DATA_B = 8'h0c;
  // control register field positions
  localparam int BIT_START   = 0;
  localparam int BIT_PAUSE   = 1;
  localparam int BIT_CLK_LO  = 2;
  localparam int BIT_CLK_HI  = 3;
  localparam int BIT_WAVE_LO = 4;
  localparam int BIT_WAVE_HI = 5;
  localparam int BIT_IRQ_EN  = 6;
  localparam int BIT_FLAG    = 7;
  // clock source select codes
  localparam logic [1:0] CLK_EXT     = 2'h1;
  localparam logic [1:0] CLK_CASCADE = 2'h3;
  // wave control codes
  localparam logic [1:0] WAVE_OFF  = 2'h0;
  localparam logic [1:0] WAVE_LOW  = 2'h1;
  localparam logic [1:0] WAVE_HIGH = 2'h2;
  localparam logic [1:0] WAVE_LOAD = 2'h3;
  // reset and counter values
  localparam logic [7:0] CNT_ZERO  = 8'h00;
  localparam logic [7:0] CNT_TOP   = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
  // internal count tick
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TICK_PERIOD_NS = 16;
  localparam int TICK_CYC       = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] TICK_LAST = 2'(TICK_CYC - 1);
  localparam logic [1:0] TICK_ZERO = 2'h0;
  // bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;
endpackage

// [hw/dtc_ahb_slave.sv]
// zero-wait AHB-Lite slave front end for the timer registers
`timescale 1ns/1ns
module dtc_ahb_slave (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave port
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // register side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_word
);
  typedef struct packed {
    logic        wpend;
    logic [7:0]  waddr;
    logic [31:0] rdata;
  } dtc_ahb_state_type;

  dtc_ahb_state_type q;
  dtc_ahb_state_type c;
  logic              take;

  // only whole-word single transfers are issued by the master
  assign take      = hsel && hready && (htrans == dtc_pkg::HTRANS_NONSEQ) && (hsize == 3'h2);
  assign hreadyout = 1'b1;
  assign hresp     = dtc_pkg::HRESP_OKAY;
  assign hrdata    = q.rdata;
  assign wr_en     = q.wpend;
  assign wr_addr   = q.waddr;
  assign wr_data   = hwdata[7:0];
  assign rd_addr   = haddr[7:0];

  always_comb begin
    c       = q;
    // writes outside the mapped window are dropped
    c.wpend = take && hwrite && (haddr[31:8] == 24'h00_0000);
    if (take) begin
      c.waddr = haddr[7:0];
    end
    // read word captured at the address phase, stands in the data phase
    if (take && !hwrite) begin
      c.rdata = (haddr[31:8] == 24'h00_0000) ? rd_word : dtc_pkg::RD_ZERO;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= c;
    end
  end
endmodule

// [hw/dtc_wave.sv]
// square-wave output with programmable initial level
`timescale 1ns/1ns
module dtc_wave (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       ctl_wr,
  input  wire logic [1:0] ctl_val,
  input  wire logic       stopped,
  input  wire logic       toggle,
  // outputs
  output logic [1:0]      field,
  output logic            pin
);
  typedef struct packed {
    logic [1:0] field;
    logic       lvl;
    logic       out;
  } dtc_wave_state_type;

  dtc_wave_state_type q;
  dtc_wave_state_type c;

  assign field = q.field;
  assign pin   = (q.field != dtc_pkg::WAVE_OFF) ? q.out : 1'b0; // RULE8

  always_comb begin
    c = q;
    if (toggle) begin
      c.out = ~q.out; // RULE8
    end
    if (ctl_wr) begin
      c.field = ctl_val;
      case (ctl_val)
        dtc_pkg::WAVE_LOW: begin
          c.lvl = 1'b0; // RULE16
        end
        dtc_pkg::WAVE_HIGH: begin
          c.lvl = 1'b1; // RULE16
        end
        dtc_pkg::WAVE_LOAD: begin
          if (stopped) begin
            c.out = q.lvl; // RULE15 RULE17
          end
        end
        default: begin
          c.lvl = q.lvl;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= c;
    end
  end
endmodule

// [verif/dtc_pulse_src.sv]
// external count pulse source and square-wave load for the dual timer
`timescale 1ns/1ns
module dtc_pulse_src (
  // clock
  input  wire logic hclk,
  // count pulses
  output logic      ext_a,
  output logic      ext_b,
  // wave load
  input  wire logic wave_a
);
  int   flips_a = 0;
  logic last_a  = 1'b0;

  initial begin
    ext_a = 1'b0;
    ext_b = 1'b0;
  end

  // one high cycle per pulse, then one plus gap low cycles
  task automatic pulse(input bit sel_b, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      {ext_b, ext_a} <= sel_b ? 2'b10 : 2'b01;
      @(posedge hclk);
      {ext_b, ext_a} <= 2'b00;
      repeat (gap) @(posedge hclk);
    end
  endtask

  // counts level changes seen by the load
  always @(posedge hclk) begin
    if (wave_a !== last_a) begin
      flips_a <= flips_a + 1;
    end
    last_a <= wave_a;
  end
endmodule

// [verif/test_dual_8bit_cascadable_timer.sv]
// self-checking bench for the dual cascadable timer
`timescale 1ns/1ns
module test_dual_8bit_cascadable_timer;
  logic        hclk, hresetn, hsel, hwrite, stop_mode, watch_mode, hready;
  logic        hreadyout, hresp, pin_a, pin_b, irq, ext_a, ext_b;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [1:0]  wseq [4] = '{dtc_pkg::WAVE_LOW, dtc_pkg::WAVE_LOAD, dtc_pkg::WAVE_HIGH, dtc_pkg::WAVE_LOAD};
  int          seed = 32'h1f24_9894;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  assign hready = hreadyout;

  dtc_timer dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_a_ext_count(ext_a), .timer_b_ext_count(ext_b), .stop_mode(stop_mode), .watch_mode(watch_mode),
    .timer_a_wave_pin(pin_a), .timer_b_wave_pin(pin_b), .shared_timer_irq(irq)
  );

  dtc_pulse_src src (.hclk(hclk), .ext_a(ext_a), .ext_b(ext_b), .wave_a(pin_a));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // single word transfer, each phase held until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= 32'(a);
    htrans <= dtc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= 32'(d);
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", 32'(dtc_pkg::HRESP_OKAY), 32'(hresp));
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask

  function automatic logic [7:0] c_adr(input bit t);
    return t ? dtc_pkg::OFS_CTRL_B : dtc_pkg::OFS_CTRL_A;
  endfunction

  function automatic logic [7:0] d_adr(input bit t);
    return t ? dtc_pkg::OFS_DATA_B : dtc_pkg::OFS_DATA_A;
  endfunction

  // control byte, msb first: flag, enable, wave, clock, pause, start
  function automatic logic [7:0] ctl(input logic st, input logic pa, input logic [1:0] ck, input logic [1:0] wv,
                                     input logic en, input logic fl);
    return {fl, en, wv, ck, pa, st};
  endfunction

  initial begin
    logic [31:0] q, q2;
    int          n, k, t0;
    {hresetn, hsel, hwrite, stop_mode, watch_mode} = 5'h00;
    haddr  = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    hsize  = 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // four registers then one unmapped word
    for (int i = 0; i < 5; i++) begin
      rreg(8'(4 * i), q);
      chk("reset read", dtc_pkg::RD_ZERO, q);
    end
    // interval on the internal tick, irq disabled
    n = 2 + ($unsigned($random(seed)) % 8);
    wreg(d_adr(0), 8'(n));
    wreg(c_adr(0), ctl(1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0));
    t0 = cyc;
    do rreg(c_adr(0), q); while (q[7] !== 1'b1 && cyc < t0 + 200);
    chk("match time", 32'h0000_0001, 32'(cyc - t0 >= 4 * n && cyc - t0 <= 4 * n + 9));
    chk("flag without enable", 32'h0000_0001, 32'(q[7]));
    #1 chk("irq masked", 32'h0000_0000, 32'(irq));
    wreg(c_adr(0), ctl(1'b1, 1'b0, 2'h0, 2'h0, 1'b1, 1'b1));
    #1 chk("irq on enable", 32'h0000_0001, 32'(irq));
    wreg(c_adr(0), ctl(1'b0, 1'b0, 2'h0, 2'h0, 1'b1, 1'b0));
    #1 chk("irq after clear", 32'h0000_0000, 32'(irq));
    // pause, stop mode, watch mode; top compare so no match intervenes
    wreg(d_adr(0), dtc_pkg::CNT_TOP);
    wreg(c_adr(0), ctl(1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0));
    for (int m = 0; m < 3; m++) begin
      repeat (40) @(posedge hclk);
      if (m == 0) begin
        wreg(c_adr(0), ctl(1'b1, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0));
      end else begin
        {watch_mode, stop_mode} <= 2'(m);
      end
      rreg(d_adr(0), q);
      repeat (40) @(posedge hclk);
      rreg(d_adr(0), q2);
      chk("held count", q, q2);
      {watch_mode, stop_mode} <= 2'h0;
      wreg(c_adr(0), ctl(1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0));
      repeat (20) @(posedge hclk);
      rreg(d_adr(0), q2);
      chk("resumed count", 32'h0000_0001, 32'(q2 > q && q2 <= q + 9));
    end
    // start from stopped states 00 and 10 clears the count
    for (int s = 0; s < 2; s++) begin
      repeat (40) @(posedge hclk);
      wreg(c_adr(0), ctl(1'b0, 1'(s), 2'h0, 2'h0, 1'b0, 1'b0));
      wreg(c_adr(0), ctl(1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0));
      rreg(d_adr(0), q);
      chk("restart clears", 32'h0000_0001, 32'(q <= 2));
    end
    // external counting on each timer, irq enabled on timer b only
    for (int t = 0; t < 2; t++) begin
      k = 1 + ($unsigned($random(seed)) % 20);
      wreg(c_adr(1'(t)), 8'h00);
      wreg(d_adr(1'(t)), 8'(k));
      wreg(c_adr(1'(t)), ctl(1'b1, 1'b0, dtc_pkg::CLK_EXT, 2'h0, 1'(t), 1'b0));
      src.pulse(1'(t), k, $unsigned($random(seed)) % 3);
      repeat (4) @(posedge hclk);
      rreg(d_adr(1'(t)), q);
      chk("external count", 32'(k), q);
      src.pulse(1'(t), 1, 0);
      repeat (4) @(posedge hclk);
      rreg(d_adr(1'(t)), q);
      chk("count after match", dtc_pkg::RD_ZERO, q);
      rreg(c_adr(1'(t)), q);
      chk("own flag", 32'h0000_0001, 32'(q[7]));
      #1 chk("shared irq", 32'(t), 32'(irq));
      chk("gated pin", 32'h0000_0000, 32'(t ? pin_b : pin_a));
    end
    // wave preset while stopped: low, load, latch high, load
    foreach (wseq[w]) begin
      wreg(c_adr(0), ctl(1'b0, 1'b0, dtc_pkg::CLK_EXT, wseq[w], 1'b0, 1'b0));
      #1 if (w > 0) chk("preset pin", 32'(w == 3), 32'(pin_a));
    end
    wreg(d_adr(0), dtc_pkg::CNT_ZERO);
    wreg(c_adr(0), ctl(1'b1, 1'b0, dtc_pkg::CLK_EXT, dtc_pkg::WAVE_LOAD, 1'b0, 1'b0));
    k = src.flips_a;
    n = 1 + ($unsigned($random(seed)) % 9);
    src.pulse(1'b0, n, 1);
    repeat (4) @(posedge hclk);
    chk("pin toggles", 32'(n), 32'(src.flips_a - k));
    chk("pin level", 32'(n[0] == 1'b0), 32'(pin_a));
    wreg(c_adr(0), ctl(1'b1, 1'b0, dtc_pkg::CLK_EXT, n[0] ? dtc_pkg::WAVE_HIGH : dtc_pkg::WAVE_LOW, 1'b0, 1'b0));
    wreg(c_adr(0), ctl(1'b1, 1'b0, dtc_pkg::CLK_EXT, dtc_pkg::WAVE_LOAD, 1'b0, 1'b0));
    #1 chk("running preset", 32'(n[0] == 1'b0), 32'(pin_a));
    // stop written in the very cycle of a match edge: no flag
    fork
      wreg(c_adr(0), 8'h00);
      begin
        @(posedge hclk);
        src.pulse(1'b0, 1, 0);
      end
    join
    rreg(c_adr(0), q);
    chk("stop beats match", 32'h0000_0000, 32'(q[7]));
    // cascade: match only on the full sixteen bit value 0102
    wreg(c_adr(1), ctl(1'b0, 1'b0, dtc_pkg::CLK_CASCADE, 2'h0, 1'b0, 1'b0));
    wreg(d_adr(0), 8'h02);
    wreg(d_adr(1), 8'h01);
    wreg(c_adr(0), ctl(1'b1, 1'b0, dtc_pkg::CLK_EXT, 2'h0, 1'b1, 1'b0));
    src.pulse(1'b0, 258, 0);
    repeat (4) @(posedge hclk);
    rreg(d_adr(0), q);
    chk("low byte", 32'h0000_0002, q);
    rreg(d_adr(0), q2);
    chk("low byte again", q, q2);
    rreg(d_adr(1), q);
    chk("high byte", 32'h0000_0001, q);
    rreg(c_adr(0), q);
    chk("no byte match", 32'h0000_0000, 32'(q[7]));
    src.pulse(1'b0, 1, 0);
    repeat (4) @(posedge hclk);
    rreg(c_adr(0), q);
    chk("cascade flag", 32'h0000_0001, 32'(q[7]));
    #1 chk("cascade irq", 32'h0000_0001, 32'(irq));
    rreg(d_adr(0), q);
    chk("low cleared", dtc_pkg::RD_ZERO, q);
    rreg(d_adr(1), q);
    chk("high cleared", dtc_pkg::RD_ZERO, q);
    results();
  end
endmodule
